// File: inc/dac_pkg.sv
// Constants for the second converter channel update and justify control.
// Assumes an AHB-Lite slave with 32-bit words and on-chip timer overflow pulses.
// Notes on behaviour
// (RULE_01) Trigger select 00: output loads on a software write of the high byte.
// (RULE_02) Trigger select 01: output loads on each timer 3 overflow.
// (RULE_03) Trigger select 10 loads on timer 4 overflow, 11 on timer 2.
// (RULE_04) Trigger select is two bits at control bits 4 and 3, read/write.
// (RULE_05) Justify 000: word is high[3:0] then the whole low byte.
// (RULE_06) Justify 001: word is high[4:0] then low[7:1].
// (RULE_07) Justify 010: word is high[5:0] then low[7:2].
// (RULE_08) Justify 011: word is high[6:0] then low[7:3].
// (RULE_09) Justify 1xx: word is the whole high byte then low[7:4].
// (RULE_10) Control register resets to zero: disabled, write trigger, justify 000.
// (RULE_11) Enable 0 keeps the converter shut down; 1 runs it and takes updates.
package dac_pkg;
  localparam logic [7:0] DAC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] DAC_OFS_HIGH = 8'h04;
  localparam logic [7:0] DAC_OFS_LOW = 8'h08;
  localparam logic [7:0] DAC_OFS_OUTPUT = 8'h0c;
  localparam logic [7:0] DAC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DAC_CTRL_WMASK = 8'h9f;
  localparam int DAC_BIT_ENABLE = 7;
  localparam int DAC_BIT_TRIG_HI = 4;
  localparam int DAC_BIT_TRIG_LO = 3;
  localparam int DAC_BIT_JUST_HI = 2;
  localparam int DAC_BIT_JUST_LO = 0;
  localparam logic [1:0] DAC_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    DAC_TRIG_WRITE = 2'b00,
    DAC_TRIG_TMR3 = 2'b01,
    DAC_TRIG_TMR4 = 2'b10,
    DAC_TRIG_TMR2 = 2'b11
  } dac_trig_t;
endpackage : dac_pkg

// File: design/dac_justify.sv
// Aligns the high and low data bytes into a 12-bit converter word.
// Assumes both bytes and the format select come from registers on the same clock.
`timescale 1ns/1ps
module dac_justify (
  input wire logic [7:0] high_byte,
  input wire logic [7:0] low_byte,
  input wire logic [2:0] format_sel,
  output logic [11:0] word
);
  // Format picks how many word bits come from the high byte
  always_comb begin
    if (format_sel[2]) begin
      // (RULE_09) eight-bit high part
      word = {high_byte[7:0], low_byte[7:4]};
    end else begin
      unique case (format_sel[1:0])
        // (RULE_05) four-bit high part
        2'b00: word = {high_byte[3:0], low_byte[7:0]};
        // (RULE_06) five-bit high part
        2'b01: word = {high_byte[4:0], low_byte[7:1]};
        // (RULE_07) six-bit high part
        2'b10: word = {high_byte[5:0], low_byte[7:2]};
        // (RULE_08) seven-bit high part
        2'b11: word = {high_byte[6:0], low_byte[7:3]};
      endcase
    end
  end
endmodule : dac_justify

// File: design/dac_update_ctrl.sv
// Second converter channel control: registers, update trigger and output word.
// Assumes an AHB-Lite master of single word transfers and timer overflow pulses.
// Assumes the overflow pins may change at any time relative to SYS_CLK.
`timescale 1ns/1ps
module dac_update_ctrl (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Timer overflow pins
  input wire logic TMR2_OVF,
  input wire logic TMR3_OVF,
  input wire logic TMR4_OVF,
  // Converter side
  output logic [11:0] DAC_CODE,
  output logic DAC_ENABLE
);
  // Software registers and their next values
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] high_q;
  logic [7:0] high_d;
  logic [7:0] low_q;
  logic [7:0] low_d;
  // Output word and enable as driven to the converter
  logic [11:0] code_q;
  logic [11:0] code_d;
  logic en_q;
  // Bus data phase state and read data
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  // Overflow pin synchronisers and edge history, one bit per timer
  logic [2:0] t_s1_q;
  logic [2:0] t_s2_q;
  logic [2:0] t_s3_q;
  // Aligned words and the update trigger
  logic [11:0] word;
  logic [11:0] word_wr;
  logic trig_hit;

  // Address phase decode: a transfer is taken when selected, ready and NONSEQ
  wire access = HSEL && HREADY && (HTRANS == dac_pkg::DAC_HTRANS_NONSEQ);
  wire rd_go = access && !HWRITE;
  wire wr_go = access && HWRITE;

  // Data phase decode: the write lands one cycle after its address phase
  // Unmapped offsets match no register, so such writes are dropped
  wire wr_ctrl = wr_pend_q && (wr_addr_q == dac_pkg::DAC_OFS_CONTROL);
  wire wr_high = wr_pend_q && (wr_addr_q == dac_pkg::DAC_OFS_HIGH);
  wire wr_low = wr_pend_q && (wr_addr_q == dac_pkg::DAC_OFS_LOW);

  // (RULE_04) two-bit trigger field
  wire [1:0] trig_sel = ctrl_q[dac_pkg::DAC_BIT_TRIG_HI:dac_pkg::DAC_BIT_TRIG_LO];
  // Justify select and channel enable; a change applies from the next clock
  wire [2:0] just_sel = ctrl_q[dac_pkg::DAC_BIT_JUST_HI:dac_pkg::DAC_BIT_JUST_LO];
  wire enabled = ctrl_q[dac_pkg::DAC_BIT_ENABLE];

  // Overflow edges, read after two synchroniser stages; a held level counts once
  // A pin needs one low cycle between overflows for both to count
  wire tmr2_evt = t_s2_q[0] && !t_s3_q[0];
  wire tmr3_evt = t_s2_q[1] && !t_s3_q[1];
  wire tmr4_evt = t_s2_q[2] && !t_s3_q[2];

  // Trigger selection for an output update; unselected sources may pulse freely
  always_comb begin
    unique case (dac_pkg::dac_trig_t'(trig_sel))
      // (RULE_01) high byte write
      dac_pkg::DAC_TRIG_WRITE: trig_hit = wr_high;
      // (RULE_02) timer 3 overflow
      dac_pkg::DAC_TRIG_TMR3: trig_hit = tmr3_evt;
      // (RULE_03) timer 4 or 2 overflow
      dac_pkg::DAC_TRIG_TMR4: trig_hit = tmr4_evt;
      dac_pkg::DAC_TRIG_TMR2: trig_hit = tmr2_evt;
    endcase
  end

  // (RULE_11) updates only while enabled; a shut down channel drops its triggers
  wire load_out = trig_hit && enabled;

  // Word alignment of the buffered bytes
  dac_justify u_justify (
    .high_byte(high_q),
    .low_byte(low_q),
    .format_sel(just_sel),
    .word(word)
  );

  // Same alignment with the high byte of the data phase, so a write trigger
  // loads the byte being written rather than the one it replaces
  dac_justify u_justify_wr (
    .high_byte(HWDATA[7:0]),
    .low_byte(low_q),
    .format_sel(just_sel),
    .word(word_wr)
  );

  // Next register values; the write mask keeps control bits 6:5 at zero
  assign ctrl_d = wr_ctrl ? (HWDATA[7:0] & dac_pkg::DAC_CTRL_WMASK) : ctrl_q;
  assign high_d = wr_high ? HWDATA[7:0] : high_q;
  assign low_d = wr_low ? HWDATA[7:0] : low_q;

  // Next output word; justify applies when the word loads, not when bytes are written
  // (RULE_01) a high byte write loads with the new byte
  assign code_d = !load_out ? code_q : (wr_high ? word_wr : word);

  // Read mux on next values, so a read right behind a write sees that write
  // Unmapped offsets read zero; the output word sits in the low twelve bits
  always_comb begin
    rdata_d = '0;
    unique case (HADDR)
      dac_pkg::DAC_OFS_CONTROL: rdata_d[7:0] = ctrl_d;
      dac_pkg::DAC_OFS_HIGH: rdata_d[7:0] = high_d;
      dac_pkg::DAC_OFS_LOW: rdata_d[7:0] = low_d;
      dac_pkg::DAC_OFS_OUTPUT: rdata_d[11:0] = code_d;
      default: rdata_d = '0;
    endcase
  end

  // Write bookkeeping: HWDATA follows its address by one cycle,
  // so the address is kept until the data phase
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_go;
      if (wr_go) begin
        wr_addr_q <= HADDR;
      end
    end
  end

  // Read data: captured at the address phase so HRDATA comes from a flip-flop
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      if (rd_go) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Control register
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      // (RULE_10) control clears to zero
      ctrl_q <= dac_pkg::DAC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Buffered data bytes; writing the low byte never moves the output by itself
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      high_q <= 8'h00;
      low_q <= 8'h00;
    end else begin
      high_q <= high_d;
      low_q <= low_d;
    end
  end

  // Overflow synchronisers; only the second stage and the history are read,
  // so an overflow reaches the output three clocks after its pin rises
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      t_s1_q <= 3'h0;
      t_s2_q <= 3'h0;
      t_s3_q <= 3'h0;
    end else begin
      t_s1_q <= {TMR4_OVF, TMR3_OVF, TMR2_OVF};
      t_s2_q <= t_s1_q;
      t_s3_q <= t_s2_q;
    end
  end

  // Output word: changes only on a chosen trigger while enabled
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      code_q <= 12'h000;
    end else begin
      code_q <= code_d;
    end
  end

  // (RULE_11) shutdown follows enable
  // Lags the control bit by one clock; each load is gated by the control bit itself, without the lag
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enabled;
    end
  end

  // HRDATA, DAC_CODE and DAC_ENABLE from flip-flops; every access completes at once with OKAY
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign DAC_CODE = code_q;
  assign DAC_ENABLE = en_q;
endmodule : dac_update_ctrl

// File: verification/dac_update_ctrl_chk.sv
// Checker for the converter control block: bus reads, enable and output word.
// Assumes one bus transfer at a time and timer mode changes with timers low.
`timescale 1ns/1ps
module dac_update_ctrl_chk (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic TMR2_OVF,
  input wire logic TMR3_OVF,
  input wire logic TMR4_OVF,
  input wire logic [11:0] DAC_CODE,
  input wire logic DAC_ENABLE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic ph_q, w_q, e_q;
  logic [7:0] a_q, hi_q, lo_q;
  logic [1:0] t_q;
  logic [2:0] j_q;
  // Address phase decode, selected timer and expected word from the mirror
  wire take = HSEL && HREADY && HTRANS == dac_pkg::DAC_HTRANS_NONSEQ;
  wire tsel = t_q == 2'h1 ? TMR3_OVF : t_q == 2'h2 ? TMR4_OVF : t_q == 2'h3 && TMR2_OVF;
  wire [15:0] sh = {hi_q, lo_q} >> (j_q[2] ? 3'h4 : {1'b0, j_q[1:0]});
  // Mirror of the registers as the data phases write them
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      {ph_q, w_q, e_q, a_q, hi_q, lo_q, t_q, j_q} <= '0;
    end else begin
      ph_q <= take && !HWRITE;
      w_q <= take && HWRITE;
      if (take) a_q <= HADDR;
      if (w_q && a_q == 8'h00) {e_q, t_q, j_q} <= {HWDATA[7], HWDATA[4:0]};
      if (w_q && a_q == 8'h04) hi_q <= HWDATA[7:0];
      if (w_q && a_q == 8'h08) lo_q <= HWDATA[7:0];
    end
  end
  a_reset_idle: assert property ($rose(NRST) |-> DAC_CODE == 12'h000 && !DAC_ENABLE)
    else $error("outputs not idle after reset");
  a_off_stable: assert property (!DAC_ENABLE [*4] |-> $stable(DAC_CODE))
    else $error("output word moved while disabled");
  a_ctrl_read: assert property (ph_q && a_q == 8'h00 |-> HRDATA == {24'h0, e_q, 2'h0, t_q, j_q})
    else $error("control read back wrong");
  a_enable_lag: assert property (w_q && a_q == 8'h00 |=> ##[0:1] DAC_ENABLE == e_q)
    else $error("enable output late");
  a_write_load: assert property (w_q && a_q == 8'h04 && t_q == 2'h0 && e_q |=> DAC_CODE == sh[11:0])
    else $error("high byte write did not load word");
  a_low_no_load: assert property (w_q && a_q == 8'h08 && t_q == 2'h0 |=> $stable(DAC_CODE))
    else $error("low byte write loaded word");
  a_timer_load: assert property ($rose(tsel) && e_q |-> ##3 DAC_CODE == sh[11:0])
    else $error("timer overflow did not load word");
  a_read_code: assert property (ph_q && a_q == 8'h0c |-> HRDATA == {20'h0, DAC_CODE})
    else $error("output word read back wrong");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or response not OKAY");
endmodule : dac_update_ctrl_chk
bind dac_update_ctrl dac_update_ctrl_chk chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .TMR2_OVF(TMR2_OVF), .TMR3_OVF(TMR3_OVF), .TMR4_OVF(TMR4_OVF), .DAC_CODE(DAC_CODE),
  .DAC_ENABLE(DAC_ENABLE));

// File: verification/tb_dac_update_ctrl.sv
// Testbench for the converter control block: registers, triggers and alignment.
// Assumes a zero wait state slave whose ready output feeds its ready input.
`timescale 1ns/1ps
module tb_dac_update_ctrl;
  logic sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, en, rdy, resp;
  logic [7:0] haddr = '0, h, l;
  logic [1:0] htrans = '0;
  logic [2:0] tmr = '0, f;
  logic [31:0] hwdata = '0, hrdata, r;
  logic [11:0] code, exp;
  int errors = 0, checked = 0;
  dac_update_ctrl dut (.SYS_CLK(sys_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy),
    .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(resp), .TMR2_OVF(tmr[0]),
    .TMR3_OVF(tmr[1]), .TMR4_OVF(tmr[2]), .DAC_CODE(code), .DAC_ENABLE(en));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic print_verdict;
    $display("Counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits for ready at a rising edge, with a bound
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask : wait_rdy
  // One single word transfer: address phase, then data phase
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus
  task automatic pulse(int i);
    tmr[i] <= 1'b1;
    @(posedge sys_clk);
    tmr[i] <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : pulse
  function automatic logic [11:0] just(logic [7:0] hb, logic [7:0] lb, logic [2:0] fs);
    logic [15:0] w;
    w = {hb, lb} >> (fs[2] ? 4 : fs[1:0]);
    return w[11:0];
  endfunction : just
  initial begin
    void'($urandom(73));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    bus(0, 8'h00, 0); chk("control", 0, r);
    bus(0, 8'h10, 0); chk("unmapped", 0, r);
    chk("enable", 0, en);
    $display("Test reset values done");
    exp = 12'h000;
    for (int k = 0; k < 8; k++) begin
      f = 3'(k);
      bus(1, 8'h00, {24'($urandom), 1'b1, 2'h3, 2'h0, f});
      bus(0, 8'h00, 0); chk("control", {24'h0, 1'b1, 4'h0, f}, r);
      {h, l} = k == 0 ? 16'hff00 : 16'($urandom);
      bus(1, 8'h08, {24'h0, l});
      bus(0, 8'h0c, 0); chk("code", {20'h0, exp}, r);
      bus(1, 8'h04, {24'h0, h});
      exp = just(h, l, f);
      bus(0, 8'h0c, 0); chk("code", {20'h0, exp}, r);
      chk("code pin", {20'h0, exp}, code);
      chk("enable", 1, en);
    end
    $display("Test write trigger and formats done");
    for (int m = 1; m < 4; m++) begin
      f = 3'($urandom);
      bus(1, 8'h00, {24'h0, 1'b1, 2'h0, 2'(m), f});
      {h, l} = 16'($urandom);
      bus(1, 8'h08, {24'h0, l});
      bus(1, 8'h04, {24'h0, h});
      pulse((m + 1) % 3);
      pulse((m + 2) % 3);
      bus(0, 8'h0c, 0); chk("code held", {20'h0, exp}, r);
      pulse(m % 3);
      exp = just(h, l, f);
      bus(0, 8'h0c, 0); chk("code timer", {20'h0, exp}, r);
    end
    $display("Test timer triggers done");
    bus(1, 8'h00, 32'h0000_0008);
    bus(1, 8'h04, 32'h0000_005a);
    pulse(1);
    bus(1, 8'h00, 32'h0000_0000);
    bus(1, 8'h04, 32'h0000_00a5);
    bus(0, 8'h0c, 0); chk("code off", {20'h0, exp}, r);
    chk("enable off", 0, en);
    $display("Test disabled channel done");
    bus(1, 8'h00, 32'h0000_009f);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    bus(0, 8'h00, 0); chk("control", 0, r);
    bus(0, 8'h0c, 0); chk("code reset", 0, r);
    chk("code pin reset", 0, code);
    chk("enable reset", 0, en);
    $display("Test second reset done");
    print_verdict();
  end
endmodule : tb_dac_update_ctrl
